// [frep_top.sv]
// flash row erase/program sequencer with unlock key and cpu stall
//==========================================================
// Function
// - erase and program whole rows of 32 instructions
// - row erase is op field 011000 with erase and write-permit set
// - start refused unless the key sequence immediately preceded it
// - start with erase runs erase, stalls cpu, self-clears start
// - row program is op 011000, erase clear, write-permit set
// - start with program runs write, stalls cpu, self-clears start
//==========================================================
`default_nettype none
module frep_top #(
    parameter int unsigned ERASE_CYCLES = frep_pkg::ERASE_CYC,
    parameter int unsigned PROG_CYCLES = frep_pkg::PROG_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [frep_pkg::ADDR_W-1:0] addr,
    input wire logic [frep_pkg::CTRL_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [frep_pkg::CTRL_W-1:0] rdata,
    output logic cpu_stall,
    output logic fl_erase,
    output logic fl_prog,
    output logic [frep_pkg::CTRL_W-1:0] fl_page,
    output logic [frep_pkg::CTRL_W-1:0] fl_offs,
    output logic [frep_pkg::WORD_W-1:0] fl_wdata,
    output logic [frep_pkg::WIDX_W-1:0] fl_widx
);
    typedef enum logic [2:0] {
        FREP_IDLE = 3'b001,
        FREP_ERASE = 3'b010,
        FREP_PROG = 3'b100
    } frep_state_t;

    //==========================================================
    // registers
    frep_state_t state_reg, state_next;
    logic [15:0] ctrl_reg;
    logic [15:0] page_reg;
    logic [15:0] offs_reg;
    logic [15:0] wlo_reg;
    logic [1:0] key_reg;
    logic [19:0] cnt_reg;
    logic [15:0] rdata_reg;
    logic stall_reg;
    logic erase_reg;
    logic prog_reg;
    logic [4:0] widx_reg;
    logic [4:0] rptr_reg;
    logic [23:0] wdat_reg;
    logic [23:0] buf_mem [0:frep_pkg::ROW_WORDS-1];
    logic [4:0] buf_cnt_reg;
    logic fail_reg;

    //==========================================================
    // decode
    // one register written outside busy time
    function automatic logic reg_hit(
        input logic stb,
        input logic [3:0] a,
        input logic [3:0] idx,
        input logic bsy
    );
        return stb && a == idx && !bsy;
    endfunction : reg_hit

    wire busy = (state_reg != FREP_IDLE);
    wire w_ctrl = reg_hit(wr_stb, addr, frep_pkg::A_CTRL, busy);
    wire w_key = reg_hit(wr_stb, addr, frep_pkg::A_KEY, busy);
    wire w_page = reg_hit(wr_stb, addr, frep_pkg::A_PAGE, busy);
    wire w_offs = reg_hit(wr_stb, addr, frep_pkg::A_OFFS, busy);
    wire w_wlo = reg_hit(wr_stb, addr, frep_pkg::A_WDAT_LO, busy);
    wire w_whi = reg_hit(wr_stb, addr, frep_pkg::A_WDAT_HI, busy);
    wire key1 = w_key && wdata == frep_pkg::KEY_FIRST;
    wire key2 = w_key && wdata == frep_pkg::KEY_SECOND && key_reg == 2'h1;
    wire set_start = w_ctrl && wdata[frep_pkg::B_START];
    wire op_ok = wdata[frep_pkg::OP_MSB:0] == frep_pkg::OP_ROW && wdata[frep_pkg::B_WPERMIT];
    // the start write spends the unlock whether or not it is taken
    wire go = set_start && key_reg == 2'h2 && op_ok;
    wire go_erase = go && wdata[frep_pkg::B_ERASE];
    wire go_prog = go && !wdata[frep_pkg::B_ERASE];
    wire cnt_done = cnt_reg == 20'h00001;
    wire prog_next = state_next == FREP_PROG && state_reg == FREP_PROG;
    wire [15:0] start_mask = 16'h0001 << frep_pkg::B_START;
    wire [15:0] stat_word = {13'h0, fail_reg, stall_reg, key_reg == 2'h2};
    // key register is write-only and reads as zero
    wire [15:0] rd_mux = addr == frep_pkg::A_CTRL ? ctrl_reg :
                         addr == frep_pkg::A_PAGE ? page_reg :
                         addr == frep_pkg::A_OFFS ? offs_reg :
                         addr == frep_pkg::A_STAT ? stat_word : 16'h0000;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            FREP_IDLE:
            begin
                if (go_erase)
                    state_next = FREP_ERASE;
                else if (go_prog)
                    state_next = FREP_PROG;
            end
            FREP_ERASE, FREP_PROG:
            begin
                if (cnt_done)
                    state_next = FREP_IDLE;
            end
            default: state_next = FREP_IDLE;
        endcase
    end

    //==========================================================
    // control and key
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= FREP_IDLE;
            ctrl_reg <= frep_pkg::CTRL_RST;
            key_reg <= 2'h0;
            cnt_reg <= 20'h00000;
            fail_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // any write other than the expected next step drops the unlock
            if (key1)
                key_reg <= 2'h1;
            else if (key2)
                key_reg <= 2'h2;
            else if (wr_stb)
                key_reg <= 2'h0;
            if (go)
            begin
                ctrl_reg <= (wdata & frep_pkg::CTRL_WMASK) | start_mask;
                // busy lasts exactly the loaded count, last cycle included
                cnt_reg <= wdata[frep_pkg::B_ERASE] ? ERASE_CYCLES[19:0] : PROG_CYCLES[19:0];
                fail_reg <= 1'b0;
            end
            else if (w_ctrl)
            begin
                ctrl_reg <= wdata & frep_pkg::CTRL_WMASK;
                if (set_start)
                    fail_reg <= 1'b1;
            end
            else if (busy)
            begin
                cnt_reg <= cnt_reg - 20'h00001;
                if (cnt_done)
                    ctrl_reg[frep_pkg::B_START] <= 1'b0;
            end
        end
    end

    //==========================================================
    // address, buffers, bus read
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            page_reg <= 16'h0000;
            offs_reg <= 16'h0000;
            wlo_reg <= 16'h0000;
            buf_cnt_reg <= 5'h00;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            // read data last one cycle, zero otherwise
            rdata_reg <= rd_stb ? rd_mux : 16'h0000;
            if (w_page)
                page_reg <= wdata;
            if (w_offs)
                offs_reg <= wdata;
            if (w_wlo)
                wlo_reg <= wdata;
            if (w_whi)
                buf_cnt_reg <= buf_cnt_reg + 5'h01;
            if (state_reg == FREP_PROG && cnt_done)
                buf_cnt_reg <= 5'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (w_whi)
            buf_mem[buf_cnt_reg] <= {wdata[7:0], wlo_reg};
    end

    //==========================================================
    // flash side strobes, row word streaming
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stall_reg <= 1'b0;
            erase_reg <= 1'b0;
            prog_reg <= 1'b0;
            widx_reg <= 5'h00;
            rptr_reg <= 5'h00;
            wdat_reg <= 24'h000000;
        end
        else
        begin
            // stall and erase strobes follow the next state so they rise together with busy; the program strobe rises one cycle later
            stall_reg <= state_next != FREP_IDLE;
            erase_reg <= state_next == FREP_ERASE;
            prog_reg <= prog_next;
            if (state_reg == FREP_PROG)
                rptr_reg <= rptr_reg + 5'h01;
            else
                rptr_reg <= 5'h00;
            // index and word leave together so the array sees a matched pair
            widx_reg <= prog_next ? rptr_reg : 5'h00;
            wdat_reg <= buf_mem[rptr_reg];
        end
    end

    assign rdata = rdata_reg;
    assign cpu_stall = stall_reg;
    assign fl_erase = erase_reg;
    assign fl_prog = prog_reg;
    assign fl_page = page_reg;
    assign fl_offs = offs_reg;
    assign fl_wdata = wdat_reg;
    assign fl_widx = widx_reg;

    //==========================================================
    // checks
    a_start_needs_key: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(stall_reg) |-> $past(key_reg) == 2'h2)
        else $error("operation started without unlock");
    a_stall_erase: assert property (@(posedge clk) disable iff (!rst_n)
        go_erase |=> stall_reg && erase_reg && ctrl_reg[frep_pkg::B_START])
        else $error("erase did not start with stall");
    a_stall_prog: assert property (@(posedge clk) disable iff (!rst_n)
        go_prog |=> stall_reg && !erase_reg && ctrl_reg[frep_pkg::B_START])
        else $error("program did not start with stall");
    a_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
        busy && cnt_done |=> !ctrl_reg[frep_pkg::B_START] && !stall_reg)
        else $error("start bit not cleared at end");
    a_cancel_unlock: assert property (@(posedge clk) disable iff (!rst_n)
        wr_stb && !key1 && !key2 |=> key_reg == 2'h0)
        else $error("stray write kept unlock");
    a_key_order: assert property (@(posedge clk) disable iff (!rst_n)
        key_reg == 2'h2 |-> $past(key_reg) == 2'h1 || $past(key_reg) == 2'h2)
        else $error("unlock reached out of order");
    a_erase_sel: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(erase_reg) |-> ctrl_reg[frep_pkg::OP_MSB:0] == frep_pkg::OP_ROW && ctrl_reg[frep_pkg::B_ERASE])
        else $error("erase without erase selection");
    a_prog_sel: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == FREP_PROG |-> !ctrl_reg[frep_pkg::B_ERASE] && ctrl_reg[frep_pkg::B_WPERMIT])
        else $error("program with bad selection");

    // row streaming
    a_row_walk: assert property (@(posedge clk) disable iff (!rst_n)
        prog_reg && $past(prog_reg) |-> widx_reg == $past(widx_reg) + 5'h01)
        else $error("row index not stepping");
    a_word_align: assert property (@(posedge clk) disable iff (!rst_n)
        prog_reg |-> wdat_reg == buf_mem[widx_reg])
        else $error("streamed word does not match its index");
    a_prog_first: assert property (@(posedge clk) disable iff (!rst_n)
        go_prog |=> !prog_reg ##1 (prog_reg && widx_reg == 5'h00))
        else $error("program did not begin at the first word");
    a_row_count: assert property (@(posedge clk) disable iff (!rst_n)
        w_whi |=> buf_cnt_reg == $past(buf_cnt_reg) + 5'h01)
        else $error("buffer slot did not advance");

    // stall, flags and held fields
    a_stall_tracks: assert property (@(posedge clk) disable iff (!rst_n)
        stall_reg == busy)
        else $error("stall does not follow busy");
    a_erase_flag: assert property (@(posedge clk) disable iff (!rst_n)
        erase_reg == (state_reg == FREP_ERASE))
        else $error("erase strobe does not follow state");
    a_single_op: assert property (@(posedge clk) disable iff (!rst_n)
        !(erase_reg && prog_reg))
        else $error("erase and program together");
    a_refuse_flag: assert property (@(posedge clk) disable iff (!rst_n)
        set_start && !go |=> fail_reg && !ctrl_reg[frep_pkg::B_START] && !stall_reg)
        else $error("refused start left no trace");
    a_key_consumed: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(stall_reg) |-> key_reg == 2'h0)
        else $error("unlock survived the start");
    a_fields_hold: assert property (@(posedge clk) disable iff (!rst_n)
        busy |=> $stable(page_reg) && $stable(offs_reg) && $stable(ctrl_reg[frep_pkg::B_WPERMIT:0]))
        else $error("fields changed during an operation");

    //==========================================================
    // coverage
    c_erase: cover property (@(posedge clk) disable iff (!rst_n) go_erase);
    c_prog: cover property (@(posedge clk) disable iff (!rst_n) go_prog);
    c_refused: cover property (@(posedge clk) disable iff (!rst_n) set_start && !go);
    c_done: cover property (@(posedge clk) disable iff (!rst_n) busy && cnt_done);
    c_row_end: cover property (@(posedge clk) disable iff (!rst_n) prog_reg && widx_reg == 5'h1F);
endmodule : frep_top
`default_nettype wire

// [frep_pkg.sv]
// constants for the flash row erase/program sequencer
`default_nettype none
package frep_pkg;
    localparam int unsigned CTRL_W = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned ROW_WORDS = 32;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned WIDX_W = 5;
    // register indices
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_KEY = 4'h1;
    localparam logic [3:0] A_PAGE = 4'h2;
    localparam logic [3:0] A_OFFS = 4'h3;
    localparam logic [3:0] A_WDAT_LO = 4'h4;
    localparam logic [3:0] A_WDAT_HI = 4'h5;
    localparam logic [3:0] A_STAT = 4'h6;
    // control fields
    localparam int unsigned B_START = 15;
    localparam int unsigned B_WPERMIT = 14;
    localparam int unsigned B_ERASE = 6;
    localparam int unsigned OP_MSB = 5;
    localparam logic [5:0] OP_ROW = 6'h18;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h407F;
    localparam logic [15:0] KEY_FIRST = 16'h0055;
    localparam logic [15:0] KEY_SECOND = 16'h00AA;
    // timing
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned ERASE_US = 2000;
    localparam int unsigned PROG_US = 2000;
    localparam int unsigned ERASE_CYC = ERASE_US * 1000 / CLK_NS;
    localparam int unsigned PROG_CYC = PROG_US * 1000 / CLK_NS;
    localparam int unsigned CNT_W = 20;
endpackage : frep_pkg
`default_nettype wire

// [frep_flash_model.sv]
// behavioural flash row array on the far side of the sequencer
`default_nettype none
module frep_flash_model (
    input wire logic clk,
    input wire logic fl_erase,
    input wire logic fl_prog,
    input wire logic [frep_pkg::WORD_W-1:0] fl_wdata,
    input wire logic [frep_pkg::WIDX_W-1:0] fl_widx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [frep_pkg::WORD_W-1:0] row [frep_pkg::ROW_WORDS];
    // programming only clears bits, so an unerased row shows it
    always @(posedge clk)
    begin
        if (fl_erase)
            for (int i = 0; i < frep_pkg::ROW_WORDS; i++) row[i] <= '1;
        else if (fl_prog)
            row[fl_widx] <= row[fl_widx] & fl_wdata;
    end
endmodule : frep_flash_model
`default_nettype wire

// [frep_top_tb.sv]
// self-checking bench for the flash row erase/program sequencer
`default_nettype none
module frep_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned EC = 8;
    localparam int unsigned PC = 40;
    logic clk, rst_n, wr_stb, rd_stb, cpu_stall, fl_erase, fl_prog;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, fl_page, fl_offs;
    logic [23:0] fl_wdata;
    logic [4:0] fl_widx;
    logic [15:0] cs [5] = '{16'hC058, 16'hC058, 16'hC058, 16'hC050, 16'h8058};
    int errors, total_checks, n;
    frep_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) u_frep_top (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cpu_stall(cpu_stall),
        .fl_erase(fl_erase), .fl_prog(fl_prog), .fl_page(fl_page), .fl_offs(fl_offs),
        .fl_wdata(fl_wdata), .fl_widx(fl_widx));
    frep_flash_model u_frep_flash_model (.clk(clk), .fl_erase(fl_erase), .fl_prog(fl_prog),
        .fl_wdata(fl_wdata), .fl_widx(fl_widx));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge clk);
        rd_stb <= 1'b0;
        // data stand only in the cycle after the strobe
        #1 chk(24'(rdata), 24'(exp));
    endtask : rd
    task automatic end_of_test();
        $display("errors %0d total_checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    // unlock, start, then stay silent until the stall drops
    task automatic run(input logic [15:0] c, input int unsigned cyc);
        wr(frep_pkg::A_KEY, frep_pkg::KEY_FIRST);
        wr(frep_pkg::A_KEY, frep_pkg::KEY_SECOND);
        wr(frep_pkg::A_CTRL, c);
        wr_stb <= 1'b0;
        #1 chk(24'({cpu_stall, fl_erase, fl_prog}), 24'({1'b1, c[6], 1'b0}));
        n = 0;
        while (cpu_stall === 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(24'(n), 24'(cyc));
        if (n >= 2000)
        begin
            errors++;
            end_of_test();
        end
        rd(frep_pkg::A_CTRL, c & 16'h7FFF);
    endtask : run
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial
    begin
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = '0;
        wdata = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(frep_pkg::A_CTRL, frep_pkg::CTRL_RST);
        rd(4'hF, 16'h0000);
        // refused: bad key, write between keys, write before start, bad op, no permit
        for (int k = 0; k < 5; k++)
        begin
            wr(frep_pkg::A_KEY, (k == 0) ? 16'h0000 : frep_pkg::KEY_FIRST);
            if (k == 1) wr(frep_pkg::A_PAGE, 16'h0012);
            wr(frep_pkg::A_KEY, frep_pkg::KEY_SECOND);
            if (k == 2) wr(frep_pkg::A_OFFS, 16'h0040);
            wr(frep_pkg::A_CTRL, cs[k]);
            wr_stb <= 1'b0;
            #1 chk(24'(cpu_stall), 24'h0);
            rd(frep_pkg::A_CTRL, cs[k] & 16'h7FFF);
            rd(frep_pkg::A_STAT, 16'h0004);
        end
        wr(frep_pkg::A_PAGE, 16'h0012);
        wr(frep_pkg::A_OFFS, 16'h0040);
        wr_stb <= 1'b0;
        #1 chk(24'({fl_page, fl_offs[7:0]}), 24'h001240);
        run(16'hC058, EC);
        chk(u_frep_flash_model.row[31], 24'hFFFFFF);
        for (int i = 0; i < 32; i++)
        begin
            wr(frep_pkg::A_WDAT_LO, 16'(16'h1000 + i));
            wr(frep_pkg::A_WDAT_HI, 16'(16'h00C0 + i));
        end
        run(16'hC018, PC);
        for (int i = 0; i < 32; i++)
            chk(u_frep_flash_model.row[i], {8'(8'hC0 + i), 16'(16'h1000 + i)});
        rd(frep_pkg::A_STAT, 16'h0000);
        end_of_test();
    end
endmodule : frep_top_tb
`default_nettype wire
